// ===== design/buck4_setpoint_registers.sv
`timescale 1ns/1ps
// Overview of operation
// [RL1] five registers at consecutive addresses 0x4A..0x4E
// [RL2] host controls the regulator through these registers
// [RL3] normal code bits 5:0 writable, reset zero
// [RL4] range bit read-only, loaded only during configuration
// [RL5] standby code bits 5:0 writable
// [RL6] standby bit 6 shows configured range
// [RL7] sleep code bits 5:0 writable
// [RL8] sleep bit 6 mirrors configured range
// [RL9] switching mode bits 3:0 writable, reset eight
// [RL10] config holds speed, phase, frequency, limit
// [RL11] host uses low range below two volts
// [RL12] low range: 0.400 V, 25 mV steps
// [RL13] high range: 0.800 V, 50 mV steps
// [RL14] host avoids high-range codes above fifty
// [RL15] set-point bit 7 reads zero, ignores writes
module buck4_setpoint_registers
    import buck4_pkg::*;
(
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             resetn_i,
    // register access from the serial interface engine
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    input  wire logic [7:0]       reg_addr_i,
    input  wire logic [7:0]       reg_wdata_i,
    output logic      [7:0]       reg_rdata_o,
    output logic                  reg_hit_o,
    // configuration load path
    input  wire logic             cfg_load_i,
    input  wire logic             cfg_range_i,
    // settings to the regulator
    output setpoint_bundle_t      setpoints_o,
    output logic      [3:0]       switching_mode_o,
    output buck4_config_t         config_o
);

    logic       range_reg;          // shared output range
    logic [5:0] normal_code_reg;    // normal-mode code
    logic [5:0] standby_code_reg;   // standby-mode code
    logic [5:0] sleep_code_reg;     // sleep-mode code
    logic [3:0] mode_reg;           // switching mode selector
    buck4_config_t config_reg;      // speed/phase/frequency/limit
    logic [7:0] rdata_next;         // read mux result
    logic       hit_next;           // address decode result

    // range bit: only the configuration load path changes it, never the host
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            range_reg <= RANGE_RESET;
        end
        else if (cfg_load_i)
        begin
            range_reg <= cfg_range_i;  // [RL4] [RL6] [RL8]
        end
    end

    // set-point codes: host writes low six bits only; bits 7 and 6 dropped
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            normal_code_reg  <= CODE_RESET;
            standby_code_reg <= CODE_RESET;
            sleep_code_reg   <= CODE_RESET;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                NORMAL_SETPOINT_ADDR:
                begin
                    normal_code_reg <= reg_wdata_i[CODE_MSB:0];  // [RL3] [RL15]
                end
                STANDBY_SETPOINT_ADDR:
                begin
                    standby_code_reg <= reg_wdata_i[CODE_MSB:0];  // [RL5]
                end
                SLEEP_SETPOINT_ADDR:
                begin
                    sleep_code_reg <= reg_wdata_i[CODE_MSB:0];  // [RL7]
                end
                default:
                begin
                    normal_code_reg <= normal_code_reg;
                end
            endcase
        end
    end

    // switching mode and configuration registers
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            mode_reg   <= MODE_RESET;  // [RL9]
            config_reg <= CONFIG_RESET;
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == SWITCHING_MODE_ADDR)
            begin
                mode_reg <= reg_wdata_i[MODE_MSB:0];  // [RL9]
            end
            if (reg_addr_i == CONFIG_ADDR)
            begin
                config_reg <= buck4_config_t'(reg_wdata_i);  // [RL10]
            end
        end
    end

    // read decode; unmapped addresses read zero and report no hit
    always_comb
    begin
        rdata_next = 8'h00;
        hit_next   = 1'b1;
        case (reg_addr_i)  // [RL1] [RL2]
            NORMAL_SETPOINT_ADDR:
            begin
                rdata_next = {1'b0, range_reg, normal_code_reg};  // [RL15]
            end
            STANDBY_SETPOINT_ADDR:
            begin
                rdata_next = {1'b0, range_reg, standby_code_reg};  // [RL6]
            end
            SLEEP_SETPOINT_ADDR:
            begin
                rdata_next = {1'b0, range_reg, sleep_code_reg};  // [RL8]
            end
            SWITCHING_MODE_ADDR:
            begin
                rdata_next = {4'h0, mode_reg};
            end
            CONFIG_ADDR:
            begin
                rdata_next = config_reg;
            end
            default:
            begin
                hit_next = 1'b0;
            end
        endcase
    end

    // registered read data, captured on a read strobe
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            reg_rdata_o <= 8'h00;
            reg_hit_o   <= 1'b0;
        end
        else if (reg_rd_i)
        begin
            reg_rdata_o <= rdata_next;
            reg_hit_o   <= hit_next;
        end
    end

    // settings toward the regulator; range selects the step table
    always_comb
    begin
        setpoints_o.range_high   = range_reg;  // [RL12] [RL13]
        setpoints_o.normal_code  = normal_code_reg;
        setpoints_o.standby_code = standby_code_reg;
        setpoints_o.sleep_code   = sleep_code_reg;
        switching_mode_o         = mode_reg;
        config_o                 = config_reg;
    end

    // checks on the register bank, all sampled on the rising clock edge

    // a host write never disturbs the range bit
    AST_RANGE_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL4]
        !cfg_load_i |=> range_reg == $past(range_reg))
        else $error("range bit changed without a configuration load");

    // configuration load reaches the range bit
    AST_RANGE_LOAD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL4]
        cfg_load_i |=> range_reg == $past(cfg_range_i))
        else $error("range bit did not take the loaded value");

    // normal code write lands in one cycle
    AST_NORMAL_WR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL3]
        reg_wr_i && reg_addr_i == NORMAL_SETPOINT_ADDR
        |=> normal_code_reg == $past(reg_wdata_i[CODE_MSB:0]))
        else $error("normal code write lost");

    // normal read shows range and code, bit 7 zero
    AST_NORMAL_RD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL3] [RL15]
        reg_rd_i && reg_addr_i == NORMAL_SETPOINT_ADDR
        |=> reg_rdata_o == {1'b0, $past(range_reg), $past(normal_code_reg)})
        else $error("normal read data wrong");

    // standby code write lands
    AST_STANDBY_WR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL5]
        reg_wr_i && reg_addr_i == STANDBY_SETPOINT_ADDR
        |=> setpoints_o.standby_code == $past(reg_wdata_i[CODE_MSB:0]))
        else $error("standby code write lost");

    // standby read shows range and code, bit 7 zero
    AST_STANDBY_RD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL6]
        reg_rd_i && reg_addr_i == STANDBY_SETPOINT_ADDR
        |=> reg_rdata_o == {1'b0, $past(range_reg), $past(standby_code_reg)})
        else $error("standby read data wrong");

    // sleep code write lands
    AST_SLEEP_WR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL7]
        reg_wr_i && reg_addr_i == SLEEP_SETPOINT_ADDR
        |=> setpoints_o.sleep_code == $past(reg_wdata_i[CODE_MSB:0]))
        else $error("sleep code write lost");

    // sleep read mirrors the range bit
    AST_SLEEP_RD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL8]
        reg_rd_i && reg_addr_i == SLEEP_SETPOINT_ADDR
        |=> reg_rdata_o[7:6] == {1'b0, $past(range_reg)})
        else $error("sleep read range wrong");

    // mode comes out of reset at its default
    AST_MODE_RESET: assert property (@(posedge ref_clk_i)  // [RL9]
        !resetn_i |=> switching_mode_o == MODE_RESET)
        else $error("switching mode reset value wrong");

    // mode write lands, upper nibble dropped
    AST_MODE_WR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL9]
        reg_wr_i && reg_addr_i == SWITCHING_MODE_ADDR
        |=> switching_mode_o == $past(reg_wdata_i[MODE_MSB:0]))
        else $error("switching mode write lost");

    // mode read shows the selector with a zero upper nibble
    AST_MODE_RD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL9]
        reg_rd_i && reg_addr_i == SWITCHING_MODE_ADDR
        |=> reg_rdata_o == {4'h0, $past(mode_reg)})
        else $error("switching mode read data wrong");

    // config write reaches the regulator outputs
    AST_CONFIG_WR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL10]
        reg_wr_i && reg_addr_i == CONFIG_ADDR
        |=> config_o == $past(reg_wdata_i))
        else $error("config write lost");

    // config read returns all eight stored bits
    AST_CONFIG_RD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL10]
        reg_rd_i && reg_addr_i == CONFIG_ADDR
        |=> reg_rdata_o == $past(config_reg))
        else $error("config read data wrong");

    // config comes out of reset cleared
    AST_CONFIG_RESET: assert property (@(posedge ref_clk_i)  // [RL10]
        !resetn_i |=> config_o == CONFIG_RESET)
        else $error("config reset value wrong");

    // mapped addresses hit, others miss
    AST_DECODE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL1]
        reg_rd_i |=> reg_hit_o == ($past(reg_addr_i) >= NORMAL_SETPOINT_ADDR
                                   && $past(reg_addr_i) <= CONFIG_ADDR))
        else $error("address decode wrong");

    // unmapped reads return zero
    AST_MISS_RD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL1]
        reg_rd_i && (reg_addr_i < NORMAL_SETPOINT_ADDR || reg_addr_i > CONFIG_ADDR)
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped read returned data");

    // unmapped writes leave every setting alone
    AST_MISS_WR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL1]
        reg_wr_i && !cfg_load_i
        && (reg_addr_i < NORMAL_SETPOINT_ADDR || reg_addr_i > CONFIG_ADDR)
        |=> $stable(setpoints_o) && $stable(switching_mode_o) && $stable(config_o))
        else $error("unmapped write changed a setting");

    // normal code moves only on its own write
    AST_NORMAL_KEEP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL3]
        !(reg_wr_i && reg_addr_i == NORMAL_SETPOINT_ADDR)
        |=> $stable(normal_code_reg))
        else $error("normal code changed without a write");

    // standby code moves only on its own write
    AST_STANDBY_KEEP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL5]
        !(reg_wr_i && reg_addr_i == STANDBY_SETPOINT_ADDR)
        |=> $stable(standby_code_reg))
        else $error("standby code changed without a write");

    // sleep code moves only on its own write
    AST_SLEEP_KEEP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL7]
        !(reg_wr_i && reg_addr_i == SLEEP_SETPOINT_ADDR)
        |=> $stable(sleep_code_reg))
        else $error("sleep code changed without a write");

    // mode moves only on its own write
    AST_MODE_KEEP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL9]
        !(reg_wr_i && reg_addr_i == SWITCHING_MODE_ADDR)
        |=> $stable(mode_reg))
        else $error("switching mode changed without a write");

    // config moves only on its own write
    AST_CONFIG_KEEP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL10]
        !(reg_wr_i && reg_addr_i == CONFIG_ADDR)
        |=> $stable(config_reg))
        else $error("config changed without a write");

    // read data and hit flag hold between reads
    AST_RDATA_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)  // [RL2]
        !reg_rd_i |=> $stable(reg_rdata_o) && $stable(reg_hit_o))
        else $error("read answer changed without a read");

    // set points and range come out of reset cleared
    AST_SETPOINT_RESET: assert property (@(posedge ref_clk_i)  // [RL3] [RL4] [RL5] [RL7]
        !resetn_i
        |=> setpoints_o == {RANGE_RESET, CODE_RESET, CODE_RESET, CODE_RESET})
        else $error("set-point reset values wrong");

    // read answer comes out of reset cleared
    AST_RDATA_RESET: assert property (@(posedge ref_clk_i)  // [RL2]
        !resetn_i |=> reg_rdata_o == 8'h00 && !reg_hit_o)
        else $error("read answer reset values wrong");

endmodule

// ===== pkg/buck4_pkg.sv
package buck4_pkg;

    // register addresses on the serial control bus
    localparam logic [7:0] NORMAL_SETPOINT_ADDR  = 8'h4A;
    localparam logic [7:0] STANDBY_SETPOINT_ADDR = 8'h4B;
    localparam logic [7:0] SLEEP_SETPOINT_ADDR   = 8'h4C;
    localparam logic [7:0] SWITCHING_MODE_ADDR   = 8'h4D;
    localparam logic [7:0] CONFIG_ADDR           = 8'h4E;

    // field positions
    localparam int CODE_MSB   = 5;
    localparam int RANGE_BIT  = 6;
    localparam int MODE_MSB   = 3;

    // reset values
    localparam logic [5:0] CODE_RESET   = 6'h00;
    localparam logic       RANGE_RESET  = 1'b0;
    localparam logic [3:0] MODE_RESET   = 4'h8;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // configuration register fields
    typedef struct packed {
        logic [1:0] voltage_change_speed;  // bits 7:6
        logic [1:0] phase_clock;           // bits 5:4
        logic [1:0] switching_freq;        // bits 3:2
        logic       spare;                 // bit 1, storage only
        logic       current_limit;         // bit 0
    } buck4_config_t;

    // set-point codes for the three operating modes plus the shared range
    typedef struct packed {
        logic       range_high;
        logic [5:0] normal_code;
        logic [5:0] standby_code;
        logic [5:0] sleep_code;
    } setpoint_bundle_t;

endpackage

// ===== test/buck4_host_model.sv
`timescale 1ns/1ps
// host side of the register strobe bus
module buck4_host_model
(
    // clock
    input  wire logic       ref_clk_i,
    // answer from the register bank
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_hit_i,
    // requests to the register bank
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o
);
    // idle bus: strobes low, address and data carry junk
    initial
    begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'hA5;
        reg_wdata_o = 8'h5A;
    end
    // one write, held over the taking edge; callers keep codes legal
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i) #1;
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge ref_clk_i) #1;
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
    // one read, answer taken the cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(posedge ref_clk_i) #1;
        reg_rd_o = 1'b1;
        reg_addr_o = a;
        @(posedge ref_clk_i) #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        d = reg_rdata_i;
        h = reg_hit_i;
    endtask
endmodule

// ===== test/buck4_setpoint_registers_tb.sv
`timescale 1ns/1ps
module buck4_setpoint_registers_tb;
    import buck4_pkg::*;
    logic             ref_clk_i = 1'b0;  // 125 MHz clock
    logic             resetn_i = 1'b0;   // sync reset
    logic             cfg_load_i = 1'b0; // range load strobe
    logic             cfg_range_i = 1'b0;
    logic             reg_wr, reg_rd, reg_hit;
    logic       [7:0] reg_addr, reg_wdata, reg_rdata;
    setpoint_bundle_t setpoints_o;
    logic       [3:0] switching_mode_o;
    buck4_config_t    config_o;
    int               error_cnt = 0;
    int               n_compared = 0;
    logic       [7:0] rst_val [5] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00};

    always #4 ref_clk_i = ~ref_clk_i;

    buck4_host_model host (.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata),
        .reg_hit_i(reg_hit), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
    buck4_setpoint_registers DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .reg_hit_o(reg_hit),
        .cfg_load_i(cfg_load_i), .cfg_range_i(cfg_range_i), .setpoints_o(setpoints_o),
        .switching_mode_o(switching_mode_o), .config_o(config_o));

    // compare one value, count it, report a difference
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // read a register and check data and hit flag
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic eh);
        logic [7:0] d;
        logic       h;
        host.rd(a, d, h);
        chk(d, e);
        chk({7'h00, h}, {7'h00, eh});
    endtask
    // hold reset low for 16 cycles
    task automatic rst();
        @(posedge ref_clk_i) #1;
        resetn_i = 1'b0;
        repeat (16) @(posedge ref_clk_i);
        #1 resetn_i = 1'b1;
    endtask
    // reset values of all five registers and the mode and config outputs
    task automatic rst_chk();
        for (logic [7:0] a = 8'h4A; a <= 8'h4E; a++)
            rd_chk(a, rst_val[a - 8'h4A], 1'b1);
        chk({1'b0, switching_mode_o, 3'h0}, {1'b0, MODE_RESET, 3'h0});
        chk(config_o, CONFIG_RESET);
        $display("test reset values done");
    endtask
    // print counts and verdict, then stop
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog against a hung sequence
    initial
    begin
        repeat (5000) @(posedge ref_clk_i);
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        rst();
        rst_chk();
        // set-point codes: only bits 5:0 stored, bits 7:6 ignored
        for (logic [7:0] a = 8'h4A; a <= 8'h4C; a++)
        begin
            host.wr(a, 8'hF2);
            rd_chk(a, 8'h32, 1'b1);
        end
        chk({2'h0, setpoints_o.standby_code}, 8'h32);
        chk({2'h0, setpoints_o.sleep_code}, 8'h32);
        $display("test set-point codes done");
        // range load shows in bit 6 of all three set points
        @(posedge ref_clk_i) #1;
        cfg_load_i = 1'b1;
        cfg_range_i = 1'b1;
        @(posedge ref_clk_i) #1;
        cfg_load_i = 1'b0;
        cfg_range_i = 1'b0;
        chk({7'h00, setpoints_o.range_high}, 8'h01);
        host.wr(NORMAL_SETPOINT_ADDR, 8'h05);
        chk({2'h0, setpoints_o.normal_code}, 8'h05);
        rd_chk(NORMAL_SETPOINT_ADDR, 8'h45, 1'b1);
        rd_chk(STANDBY_SETPOINT_ADDR, 8'h72, 1'b1);
        rd_chk(SLEEP_SETPOINT_ADDR, 8'h72, 1'b1);
        $display("test range load done");
        // mode, configuration and unmapped places
        host.wr(SWITCHING_MODE_ADDR, 8'hF3);
        rd_chk(SWITCHING_MODE_ADDR, 8'h03, 1'b1);
        chk({4'h0, switching_mode_o}, 8'h03);
        host.wr(CONFIG_ADDR, 8'hA6);
        rd_chk(CONFIG_ADDR, 8'hA6, 1'b1);
        chk(config_o, 8'hA6);
        host.wr(8'h4F, 8'h11);
        rd_chk(CONFIG_ADDR, 8'hA6, 1'b1);
        rd_chk(8'h4F, 8'h00, 1'b0);
        rd_chk(8'h49, 8'h00, 1'b0);
        $display("test mode and config done");
        // second reset in mid-run restores defaults
        rst();
        rst_chk();
        wrap_up();
    end
endmodule
